// [cbc_pkg.sv]
// Constants shared by the transmit buffer control block.
// Assumes byte-wide registers addressed by an 8-bit register address.
package cbc_pkg;
    localparam int NUM_BUF = 3;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int PRIO_W = 2;
    localparam int SEL_W = 2;
    localparam logic [ADDR_W-1:0] ADDR_PIN_CTRL = 8'h0d;
    localparam logic [ADDR_W-1:0] ADDR_BUF0_CTRL = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_BUF0_IDH = 8'h31;
    localparam logic [ADDR_W-1:0] ADDR_BUF1_CTRL = 8'h40;
    localparam logic [ADDR_W-1:0] ADDR_BUF1_IDH = 8'h41;
    localparam logic [ADDR_W-1:0] ADDR_BUF2_CTRL = 8'h50;
    localparam logic [ADDR_W-1:0] ADDR_BUF2_IDH = 8'h51;
    localparam int BIT_ABORTED = 6;
    localparam int BIT_ARB_LOST = 5;
    localparam int BIT_TX_ERR = 4;
    localparam int BIT_TX_REQ = 3;
    localparam int BIT_PRIO_HI = 1;
    localparam int BIT_PRIO_LO = 0;
    localparam int BIT_MODE_LO = 0;
    localparam int BIT_STATE_LO = 3;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] IDH_RESET = 8'h00;
    localparam logic [NUM_BUF-1:0] MODE_RESET = 3'h0;
    localparam logic [NUM_BUF-1:0] PIN_IDLE = 3'h7;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    localparam logic [PRIO_W-1:0] PRIO_LOWEST = 2'h0;
    localparam logic [PRIO_W-1:0] PRIO_HIGHEST = 2'h3;
endpackage

// [cbc_buf_ctrl.sv]
// One transmit buffer: request bit, priority, status flags and identifier high byte.
// Assumes engine event inputs are one-cycle pulses on clk_i.
`timescale 1ns/10ps
module cbc_buf_ctrl
    import cbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_ctrl_i,
    input wire logic wr_idh_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic pin_req_i,
    input wire logic sent_i,
    input wire logic abort_i,
    input wire logic arb_lost_i,
    input wire logic bus_err_i,
    output logic [DATA_W-1:0] ctrl_o,
    output logic transmit_request_bit_o,
    output logic [PRIO_W-1:0] prio_o,
    output logic [DATA_W-1:0] idh_o
);
    logic transmit_request_bit_r, transmit_request_bit_nxt;
    logic aborted_flag_r, aborted_flag_nxt;
    logic arbitration_lost_flag_r, arbitration_lost_flag_nxt;
    logic transmit_error_flag_r, transmit_error_flag_nxt;
    logic [PRIO_W-1:0] prio_r, prio_nxt;
    logic [DATA_W-1:0] idh_r, idh_nxt;
    logic req_set, req_clr, req_rise;

    always_comb begin
        req_set = pin_req_i | (wr_ctrl_i & wdata_i[BIT_TX_REQ]);
        req_clr = sent_i | abort_i | (wr_ctrl_i & ~wdata_i[BIT_TX_REQ]);
        req_rise = req_set & ~transmit_request_bit_r;
        transmit_request_bit_nxt = req_set ? 1'b1 : (req_clr ? 1'b0 : transmit_request_bit_r);
        // An engine event in the cycle of a new request wins over the clear.
        aborted_flag_nxt = abort_i ? 1'b1 : ((req_rise | sent_i) ? 1'b0 : aborted_flag_r);
        arbitration_lost_flag_nxt = arb_lost_i ? 1'b1 : (req_rise ? 1'b0 : arbitration_lost_flag_r);
        transmit_error_flag_nxt = bus_err_i ? 1'b1 : (req_rise ? 1'b0 : transmit_error_flag_r);
        prio_nxt = wr_ctrl_i ? wdata_i[BIT_PRIO_HI:BIT_PRIO_LO] : prio_r;
        idh_nxt = wr_idh_i ? wdata_i : idh_r;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            transmit_request_bit_r <= CTRL_RESET[BIT_TX_REQ];
            aborted_flag_r <= CTRL_RESET[BIT_ABORTED];
            arbitration_lost_flag_r <= CTRL_RESET[BIT_ARB_LOST];
            transmit_error_flag_r <= CTRL_RESET[BIT_TX_ERR];
            prio_r <= CTRL_RESET[BIT_PRIO_HI:BIT_PRIO_LO];
            idh_r <= IDH_RESET;
        end else begin
            transmit_request_bit_r <= transmit_request_bit_nxt;
            aborted_flag_r <= aborted_flag_nxt;
            arbitration_lost_flag_r <= arbitration_lost_flag_nxt;
            transmit_error_flag_r <= transmit_error_flag_nxt;
            prio_r <= prio_nxt;
            idh_r <= idh_nxt;
        end
    end

    always_comb begin
        ctrl_o = READ_ZERO;
        ctrl_o[BIT_ABORTED] = aborted_flag_r;
        ctrl_o[BIT_ARB_LOST] = arbitration_lost_flag_r;
        ctrl_o[BIT_TX_ERR] = transmit_error_flag_r;
        ctrl_o[BIT_TX_REQ] = transmit_request_bit_r;
        ctrl_o[BIT_PRIO_HI:BIT_PRIO_LO] = prio_r;
    end
    assign transmit_request_bit_o = transmit_request_bit_r;
    assign prio_o = prio_r;
    assign idh_o = idh_r;

    a_sent_clears_req: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sent_i && !pin_req_i && !(wr_ctrl_i && wdata_i[BIT_TX_REQ])) |=> !transmit_request_bit_o)
        else $error("Request bit not cleared after send.");
    a_write_abort: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (transmit_request_bit_o && wr_ctrl_i && !wdata_i[BIT_TX_REQ] && !pin_req_i) |=> !transmit_request_bit_o)
        else $error("Zero write did not drop pending request.");
    a_new_req_flags: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!transmit_request_bit_o && pin_req_i && !abort_i && !arb_lost_i && !bus_err_i)
        |=> (transmit_request_bit_o && !ctrl_o[BIT_ABORTED] && !ctrl_o[BIT_ARB_LOST] && !ctrl_o[BIT_TX_ERR]))
        else $error("Flags not cleared on new request.");
    a_abort_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        abort_i |=> ctrl_o[BIT_ABORTED]
        && (!transmit_request_bit_o || $past(pin_req_i) || ($past(wr_ctrl_i) && $past(wdata_i[BIT_TX_REQ]))))
        else $error("Aborted flag not set.");
    a_arb_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        arb_lost_i |=> ctrl_o[BIT_ARB_LOST])
        else $error("Arbitration lost flag not set.");
    a_err_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        bus_err_i |=> ctrl_o[BIT_TX_ERR])
        else $error("Transmit error flag not set.");
    a_prio_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_ctrl_i |=> prio_o == $past(wdata_i[BIT_PRIO_HI:BIT_PRIO_LO]))
        else $error("Priority field not written.");
endmodule

// [cbc_tx_ctrl.sv]
// Transmit buffer control and request pin control with a byte register port.
// Assumes the register port and engine events are on clk_i; request pins are asynchronous.
`timescale 1ns/10ps
module cbc_tx_ctrl
    import cbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic config_mode_i,
    input wire logic [NUM_BUF-1:0] request_pin_n_i,
    input wire logic [NUM_BUF-1:0] tx_sent_i,
    input wire logic [NUM_BUF-1:0] tx_abort_i,
    input wire logic [NUM_BUF-1:0] tx_arb_lost_i,
    input wire logic [NUM_BUF-1:0] tx_bus_err_i,
    output logic [NUM_BUF-1:0] pending_o,
    output logic sel_valid_o,
    output logic [SEL_W-1:0] sel_buf_o,
    output logic [NUM_BUF*DATA_W-1:0] ident_high_o
);
    localparam logic [ADDR_W-1:0] CTRL_ADDR [NUM_BUF] = '{ADDR_BUF0_CTRL, ADDR_BUF1_CTRL,
                                                          ADDR_BUF2_CTRL};
    localparam logic [ADDR_W-1:0] IDH_ADDR [NUM_BUF] = '{ADDR_BUF0_IDH, ADDR_BUF1_IDH,
                                                         ADDR_BUF2_IDH};

    logic [NUM_BUF-1:0] pin_meta_r, pin_meta_nxt;
    logic [NUM_BUF-1:0] pin_sync_r, pin_sync_nxt;
    logic [NUM_BUF-1:0] pin_prev_r, pin_prev_nxt;
    logic [NUM_BUF-1:0] mode_r, mode_nxt;
    logic [NUM_BUF-1:0] pin_fall;
    logic [NUM_BUF-1:0] pin_req;
    logic [NUM_BUF-1:0] pin_state;
    logic [NUM_BUF-1:0] wr_ctrl;
    logic [NUM_BUF-1:0] wr_idh;
    logic [DATA_W-1:0] ctrl_q [NUM_BUF];
    logic [DATA_W-1:0] idh_q [NUM_BUF];
    logic [PRIO_W-1:0] prio_q [NUM_BUF];
    logic [NUM_BUF-1:0] transmit_request_bit_q;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [DATA_W-1:0] read_mux;
    logic sel_valid_r, sel_valid_nxt;
    logic [SEL_W-1:0] sel_buf_r, sel_buf_nxt;
    logic [PRIO_W-1:0] best_prio;
    logic pin_wr_ok;

    // Request pins pass two flip-flops; the edge detector looks only at the second and later.
    always_comb begin
        pin_meta_nxt = request_pin_n_i;
        pin_sync_nxt = pin_meta_r;
        pin_prev_nxt = pin_sync_r;
        pin_wr_ok = reg_wr_i && (reg_addr_i == ADDR_PIN_CTRL) && config_mode_i;
        mode_nxt = pin_wr_ok ? reg_wdata_i[BIT_MODE_LO +: NUM_BUF] : mode_r;
        pin_fall = pin_prev_r & ~pin_sync_r;
        pin_req = pin_fall & mode_r;
        pin_state = pin_sync_r & ~mode_r;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta_r <= PIN_IDLE;
            pin_sync_r <= PIN_IDLE;
            pin_prev_r <= PIN_IDLE;
            mode_r <= MODE_RESET;
        end else begin
            pin_meta_r <= pin_meta_nxt;
            pin_sync_r <= pin_sync_nxt;
            pin_prev_r <= pin_prev_nxt;
            mode_r <= mode_nxt;
        end
    end

    // Address decode for the per-buffer registers.
    always_comb begin
        for (int i = 0; i < NUM_BUF; i++) begin
            wr_ctrl[i] = reg_wr_i && (reg_addr_i == CTRL_ADDR[i]);
            wr_idh[i] = reg_wr_i && (reg_addr_i == IDH_ADDR[i]);
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_BUF; g++) begin : gen_buf
            cbc_buf_ctrl u_buf (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .wr_ctrl_i(wr_ctrl[g]),
                .wr_idh_i(wr_idh[g]),
                .wdata_i(reg_wdata_i),
                .pin_req_i(pin_req[g]),
                .sent_i(tx_sent_i[g]),
                .abort_i(tx_abort_i[g]),
                .arb_lost_i(tx_arb_lost_i[g]),
                .bus_err_i(tx_bus_err_i[g]),
                .ctrl_o(ctrl_q[g]),
                .transmit_request_bit_o(transmit_request_bit_q[g]),
                .prio_o(prio_q[g]),
                .idh_o(idh_q[g])
            );
            assign ident_high_o[g*DATA_W +: DATA_W] = idh_q[g];
        end
    endgenerate

    // Read path: unmapped addresses return zero; data appears the cycle after the strobe.
    always_comb begin
        read_mux = READ_ZERO;
        if (reg_addr_i == ADDR_PIN_CTRL) begin
            read_mux[BIT_MODE_LO +: NUM_BUF] = mode_r;
            read_mux[BIT_STATE_LO +: NUM_BUF] = pin_state;
        end
        for (int i = 0; i < NUM_BUF; i++) begin
            if (reg_addr_i == CTRL_ADDR[i]) begin
                read_mux = ctrl_q[i];
            end
            if (reg_addr_i == IDH_ADDR[i]) begin
                read_mux = idh_q[i];
            end
        end
        rdata_nxt = reg_rd_i ? read_mux : rdata_r;
    end

    // Pick the pending buffer with the highest priority; later buffers win ties.
    always_comb begin
        sel_valid_nxt = 1'b0;
        sel_buf_nxt = sel_buf_r;
        best_prio = PRIO_LOWEST;
        for (int i = 0; i < NUM_BUF; i++) begin
            if (transmit_request_bit_q[i] && (!sel_valid_nxt || prio_q[i] >= best_prio)) begin
                sel_valid_nxt = 1'b1;
                sel_buf_nxt = SEL_W'(i);
                best_prio = prio_q[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_r <= READ_ZERO;
            sel_valid_r <= 1'b0;
            sel_buf_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
            sel_valid_r <= sel_valid_nxt;
            sel_buf_r <= sel_buf_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign pending_o = transmit_request_bit_q;
    assign sel_valid_o = sel_valid_r;
    assign sel_buf_o = sel_buf_r;

    a_pin_cfg_lock: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (reg_wr_i && reg_addr_i == ADDR_PIN_CTRL && !config_mode_i) |=> $stable(mode_r))
        else $error("Pin mode changed outside configuration mode.");
    a_pin_cfg_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (reg_wr_i && reg_addr_i == ADDR_PIN_CTRL && config_mode_i)
        |=> mode_r == $past(reg_wdata_i[BIT_MODE_LO +: NUM_BUF]))
        else $error("Pin mode write lost in configuration mode.");
    a_pin_edge_req: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (mode_r[0] && pin_prev_r[0] && !pin_sync_r[0]) |=> pending_o[0])
        else $error("Falling edge did not set request.");
    a_pin_fall_path: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (mode_r[0] && $fell(pin_sync_r[0])) |=> pending_o[0])
        else $error("Pin synchroniser path broken.");
    a_pin_state_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (reg_rd_i && reg_addr_i == ADDR_PIN_CTRL)
        |=> reg_rdata_o[BIT_STATE_LO +: NUM_BUF] == ($past(pin_sync_r) & ~$past(mode_r)))
        else $error("Pin state bits read wrong.");
    a_ctrl_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (reg_rd_i && reg_addr_i == ADDR_BUF1_CTRL)
        |=> reg_rdata_o[BIT_TX_REQ] == $past(transmit_request_bit_q[1]) && !reg_rdata_o[7] && !reg_rdata_o[2])
        else $error("Control read does not show request bit.");
    a_sel_tie_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (transmit_request_bit_q[2] && prio_q[2] == PRIO_HIGHEST) |=> sel_valid_o && sel_buf_o == 2'h2)
        else $error("Highest buffer not chosen.");
    a_sel_pending: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sel_valid_o |-> $past(transmit_request_bit_q) != 3'h0)
        else $error("Selection without pending buffer.");
endmodule

// [cbc_pin_host.sv]
// Host-side driver of the three request pins.
// Assumes pins are pulled up when released; each pulse holds a pin low for 8 cycles.
`timescale 1ns/10ps
module cbc_pin_host
    import cbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic [NUM_BUF-1:0] pulse_i,
    output logic [NUM_BUF-1:0] pin_n_o
);
    int hold [NUM_BUF] = '{0, 0, 0};
    always @(posedge clk_i) begin
        for (int i = 0; i < NUM_BUF; i++) begin
            if (pulse_i[i]) begin
                hold[i] <= 8;
            end else if (hold[i] > 0) begin
                hold[i] <= hold[i] - 1;
            end
        end
    end
    // A released pin returns to the pull-up level.
    always_comb begin
        for (int i = 0; i < NUM_BUF; i++) begin
            pin_n_o[i] = (hold[i] == 0);
        end
    end
endmodule

// [testbench.sv]
// Self-checking bench for the transmit buffer control block.
// Assumes a 20 MHz clock and the host pin model beside the design.
`timescale 1ns/10ps
module testbench
    import cbc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [ADDR_W-1:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [DATA_W-1:0] reg_wdata_i = 8'h00;
    logic [DATA_W-1:0] reg_rdata_o;
    logic config_mode_i = 1'b0;
    logic [NUM_BUF-1:0] request_pin_n_i;
    logic [NUM_BUF-1:0] pin_pulse = 3'h0;
    logic [NUM_BUF-1:0] tx_sent_i = 3'h0;
    logic [NUM_BUF-1:0] tx_abort_i = 3'h0;
    logic [NUM_BUF-1:0] tx_arb_lost_i = 3'h0;
    logic [NUM_BUF-1:0] tx_bus_err_i = 3'h0;
    logic [NUM_BUF-1:0] pending_o;
    logic sel_valid_o;
    logic [SEL_W-1:0] sel_buf_o;
    logic [NUM_BUF*DATA_W-1:0] ident_high_o;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    logic [5:0] prios [3] = '{6'h2d, 6'h3f, 6'h0b};
    logic [1:0] winner [3] = '{2'h1, 2'h2, 2'h0};

    always #25 clk_i = ~clk_i;

    cbc_pin_host host (.clk_i(clk_i), .pulse_i(pin_pulse), .pin_n_o(request_pin_n_i));

    cbc_tx_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .config_mode_i(config_mode_i),
        .request_pin_n_i(request_pin_n_i), .tx_sent_i(tx_sent_i), .tx_abort_i(tx_abort_i),
        .tx_arb_lost_i(tx_arb_lost_i), .tx_bus_err_i(tx_bus_err_i), .pending_o(pending_o),
        .sel_valid_o(sel_valid_o), .sel_buf_o(sel_buf_o), .ident_high_o(ident_high_o));

    task automatic tally_and_finish();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        chk(24'(reg_rdata_o), 24'(exp));
    endtask

    // Kind 0 sent, 1 abort, 2 arbitration lost, 3 bus error, 4 pin pulse.
    task automatic ev(input int kind, input logic [2:0] m);
        @(posedge clk_i);
        case (kind)
            0: tx_sent_i <= m;
            1: tx_abort_i <= m;
            2: tx_arb_lost_i <= m;
            3: tx_bus_err_i <= m;
            default: pin_pulse <= m;
        endcase
        @(posedge clk_i);
        {tx_sent_i, tx_abort_i, tx_arb_lost_i, tx_bus_err_i, pin_pulse} <= 15'h0;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(ADDR_BUF0_CTRL, 8'h00);
        rd(ADDR_BUF1_CTRL, 8'h00);
        rd(ADDR_BUF2_CTRL, 8'h00);
        rd(8'h20, 8'h00);
        wr(ADDR_BUF0_IDH, 8'ha5);
        wr(ADDR_BUF1_IDH, 8'h5a);
        wr(ADDR_BUF2_IDH, 8'hc3);
        rd(ADDR_BUF1_IDH, 8'h5a);
        chk(ident_high_o, 24'hc35aa5);
        wr(ADDR_BUF0_CTRL, 8'h0b);
        repeat (2) @(posedge clk_i);
        #1 chk({pending_o, sel_valid_o, sel_buf_o}, 24'h0c);
        rd(ADDR_BUF0_CTRL, 8'h0b);
        ev(2, 3'h1);
        rd(ADDR_BUF0_CTRL, 8'h2b);
        ev(3, 3'h1);
        rd(ADDR_BUF0_CTRL, 8'h3b);
        ev(0, 3'h1);
        rd(ADDR_BUF0_CTRL, 8'h33);
        wr(ADDR_BUF0_CTRL, 8'h0b);
        rd(ADDR_BUF0_CTRL, 8'h0b);
        ev(1, 3'h1);
        rd(ADDR_BUF0_CTRL, 8'h43);
        wr(ADDR_BUF0_CTRL, 8'h0b);
        wr(ADDR_BUF0_CTRL, 8'h03);
        rd(ADDR_BUF0_CTRL, 8'h03);
        chk(24'(pending_o), 24'h0);
        wr(ADDR_BUF0_CTRL, 8'hff);
        rd(ADDR_BUF0_CTRL, 8'h0b);
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_BUF0_CTRL, {6'h02, prios[k][1:0]});
            wr(ADDR_BUF1_CTRL, {6'h02, prios[k][3:2]});
            wr(ADDR_BUF2_CTRL, {6'h02, prios[k][5:4]});
            repeat (2) @(posedge clk_i);
            #1 chk({sel_valid_o, sel_buf_o}, {21'h0, 1'b1, winner[k]});
            wr(ADDR_BUF0_CTRL, 8'h00);
            wr(ADDR_BUF1_CTRL, 8'h00);
            wr(ADDR_BUF2_CTRL, 8'h00);
        end
        wr(ADDR_PIN_CTRL, 8'h07);
        rd(ADDR_PIN_CTRL, 8'h38);
        @(posedge clk_i);
        config_mode_i <= 1'b1;
        wr(ADDR_PIN_CTRL, 8'hf9);
        config_mode_i <= 1'b0;
        rd(ADDR_PIN_CTRL, 8'h31);
        ev(4, 3'h1);
        repeat (8) @(posedge clk_i);
        chk(24'(pending_o), 24'h1);
        rd(ADDR_BUF0_CTRL, 8'h08);
        ev(4, 3'h2);
        repeat (3) @(posedge clk_i);
        rd(ADDR_PIN_CTRL, 8'h21);
        repeat (8) @(posedge clk_i);
        chk(24'(pending_o), 24'h1);
        tally_and_finish();
    end
endmodule
